// file: rtl/adc_frame_regs.vh
// Constants for the serial converter frame and power control block
`ifndef ADC_FRAME_REGS_VH
`define ADC_FRAME_REGS_VH
`define SAMPLE_BITS 12
`define LEAD_ZEROS 3
`define EDGE_NOISE 2
`define EDGE_MODE 10
`define EDGE_TRACK 13
`define EDGE_LAST 16
`define CODE_STEPS 4096
`define MODE_NORMAL 1'b0
`define MODE_SHUTDOWN 1'b1
`define FIFO_DEPTH 16
`define CLK_PERIOD_NS 40
`endif

// file: rtl/sample_fifo.v
// Parameterised flip-flop FIFO holding converted samples
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    // Full and empty come straight from the occupancy count
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    // Pointers and count
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
    // Storage, no reset needed on data
    always @(posedge mclk) begin
        if (do_wr)
            mem[wr_ptr] <= in_data;
    end
endmodule
`default_nettype wire

// file: rtl/adc_frame_ctrl.v
// Frame, shift-out and power-mode control of a 12-bit serial converter
// Limitations
// Every pin edge takes effect four clock cycles after it happens, so each
// phase of the link clock must last longer than that.
// The sample word is taken from the core at frame start and is not re-read.
`timescale 1ns/1ps
`default_nettype none
`include "adc_frame_regs.vh"
module adc_frame_ctrl #(
    parameter WIDTH = `SAMPLE_BITS,
    parameter DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Serial pins from the host
    input wire frame_select_n,
    input wire serial_clk,
    // Serial data pin, three-state as out and enable
    output reg serial_out,
    output reg serial_out_oe,
    // Sample from the analog core, taken at frame start
    input wire [WIDTH-1:0] sample_code,
    // Analog power and track-hold controls
    output reg analog_power_on,
    output reg hold_active,
    output reg powered_up,
    output reg mode_shutdown,
    // Converted results for local logic
    output wire result_valid,
    input wire result_ready,
    output wire [WIDTH-1:0] result_data,
    output wire result_overflow
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    reg [2:0] cs_sync;
    reg [2:0] sck_sync;
    reg cs_level;
    reg sck_level;
    // Three stages; a change counts once stages two and three agree
    // The level register is what the frame logic treats as the settled pin
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Idle levels: select high and link clock parked high, so no false edge
            cs_sync <= 3'h7;
            sck_sync <= 3'h7;
            cs_level <= 1'b1;
            sck_level <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[1:0], frame_select_n};
            sck_sync <= {sck_sync[1:0], serial_clk};
            if (cs_sync[1] == cs_sync[2])
                cs_level <= cs_sync[2];
            if (sck_sync[1] == sck_sync[2])
                sck_level <= sck_sync[2];
        end
    end
    // ==========================================================
    // Edge events
    // ==========================================================
    // An edge is flagged in the cycle in which stages two and three first agree
    // on the new level, one cycle before the level register follows. Waiting for
    // a delayed copy of the level instead would move each data change past the
    // host's next rising link clock edge at the fastest link clock.
    wire cs_low_agreed;
    wire cs_high_agreed;
    wire sck_low_agreed;
    wire sck_high_agreed;
    assign cs_low_agreed = !cs_sync[1] && !cs_sync[2];
    assign cs_high_agreed = cs_sync[1] && cs_sync[2];
    assign sck_low_agreed = !sck_sync[1] && !sck_sync[2];
    assign sck_high_agreed = sck_sync[1] && sck_sync[2];
    // Frame start and end; a select pulse seen for only one clock never counts
    wire cs_fall;
    wire cs_rise;
    assign cs_fall = cs_level && cs_low_agreed;
    assign cs_rise = !cs_level && cs_high_agreed;
    // Link clock edges; the frame logic ignores them outside a frame
    wire sck_fall;
    wire sck_rise;
    assign sck_fall = sck_level && sck_low_agreed;
    assign sck_rise = !sck_level && sck_high_agreed;
    // ==========================================================
    // Frame state
    // ==========================================================
    // wake_good marks that a full frame has run since reset or wake, so the
    // core is settled and the next full normal frame carries a valid result
    reg in_frame;
    reg wake_frame;
    reg wake_good;
    reg [4:0] fall_cnt;
    reg [4:0] rise_cnt;
    reg [14:0] shreg;
    reg [WIDTH-1:0] held_code;
    reg push;
    wire fifo_ready;
    // Edge counts, frame tracking and mode decisions
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_frame <= 1'b0;
            wake_frame <= 1'b0;
            wake_good <= 1'b0;
            fall_cnt <= 5'h00;
            rise_cnt <= 5'h00;
            mode_shutdown <= `MODE_NORMAL;
            analog_power_on <= 1'b1;
            hold_active <= 1'b0;
            powered_up <= 1'b1;
            shreg <= 15'h0000;
            held_code <= {WIDTH{1'b0}};
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            if (cs_fall) begin
                // Sample held at frame start; straight binary from the core
                in_frame <= 1'b1;
                fall_cnt <= 5'h00;
                rise_cnt <= 5'h00;
                hold_active <= 1'b1;
                held_code <= sample_code;
                shreg <= {{`LEAD_ZEROS{1'b0}}, sample_code};
                serial_out <= 1'b0;
                serial_out_oe <= 1'b1;
                wake_frame <= mode_shutdown;
                mode_shutdown <= `MODE_NORMAL;
                analog_power_on <= 1'b1;
                if (mode_shutdown)
                    powered_up <= 1'b0;
            end else if (cs_rise && in_frame) begin
                in_frame <= 1'b0;
                fall_cnt <= 5'h00;
                rise_cnt <= 5'h00;
                hold_active <= 1'b0;
                serial_out_oe <= 1'b0;
                if (wake_frame && fall_cnt < `EDGE_MODE) begin
                    // Noise guard on a wake frame: fall straight back down
                    mode_shutdown <= `MODE_SHUTDOWN;
                    analog_power_on <= 1'b0;
                end else if (fall_cnt >= `EDGE_NOISE && fall_cnt < `EDGE_MODE) begin
                    mode_shutdown <= `MODE_SHUTDOWN;
                    analog_power_on <= 1'b0;
                end
                // Before edge two nothing changes; after ten the word truncates
            end else if (in_frame) begin
                if (sck_fall && fall_cnt < `EDGE_LAST) begin
                    fall_cnt <= fall_cnt + 5'h01;
                    if (fall_cnt == `EDGE_LAST - 1) begin
                        serial_out_oe <= 1'b0;
                        // Any full frame proves the core awake; the next one is valid
                        wake_good <= 1'b1;
                        if (wake_frame) begin
                            powered_up <= 1'b1;
                        end else begin
                            // The first full frame after reset or wake is a dummy
                            // and never reaches the buffer
                            push <= wake_good;
                        end
                    end else begin
                        serial_out <= shreg[14];
                        shreg <= {shreg[13:0], 1'b0};
                    end
                end
                if (sck_rise && rise_cnt < `EDGE_LAST) begin
                    rise_cnt <= rise_cnt + 5'h01;
                    if (rise_cnt == `EDGE_TRACK - 1)
                        hold_active <= 1'b0;
                end
            end
            if (mode_shutdown)
                wake_good <= 1'b0;
        end
    end
    // Overflow marks a result lost because local logic stalled
    // The buffer drops the new word and keeps the older ones
    assign result_overflow = push && !fifo_ready;
    // ==========================================================
    // Result buffer
    // ==========================================================
    // Sixteen words let local logic stall for a whole burst of frames
    sample_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(4)
    ) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(held_code),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );
endmodule
`default_nettype wire

// file: verif/adc_frame_ctrl_sva.sv
// Concurrent checks on frame, shift-out and power-mode ports
`timescale 1ns/1ps
`default_nettype none
module adc_frame_ctrl_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Host pins
    input wire logic frame_select_n,
    input wire logic serial_clk,
    // Watched device outputs
    input wire logic serial_out_oe,
    input wire logic hold_active,
    input wire logic powered_up,
    input wire logic mode_shutdown,
    input wire logic analog_power_on
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Falls per frame, kept through the select rise so the outcome can be judged
    logic sck_q, cs_q, start_shut;
    logic [4:0] nf;
    logic [3:0] hi;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sck_q <= 1'b1;
            cs_q <= 1'b1;
            start_shut <= 1'b0;
            nf <= 5'h00;
            hi <= 4'h0;
        end else begin
            sck_q <= serial_clk;
            cs_q <= frame_select_n;
            hi <= frame_select_n ? hi + {3'h0, ~&hi} : 4'h0;
            if (cs_q && !frame_select_n) start_shut <= mode_shutdown;
            if (frame_select_n && cs_q) nf <= 5'h00;
            else if (!frame_select_n && sck_q && !serial_clk && nf != 5'h1F) nf <= nf + 5'h01;
        end
    end
    chk_oe_at_start: assert property ($fell(frame_select_n) |-> ##[1:6] serial_out_oe)
        else $error("output enable missing after frame start");
    chk_oe_at_rise: assert property ($rose(frame_select_n) |-> ##[0:6] !serial_out_oe)
        else $error("output still driven after select rise");
    chk_oe_at_last: assert property (nf == 5'h10 && $past(nf) == 5'h0F |-> ##[0:6] !serial_out_oe)
        else $error("output still driven after last falling edge");
    chk_hold_start: assert property ($fell(frame_select_n) |-> ##[1:6] hold_active)
        else $error("hold not entered at frame start");
    chk_hold_end: assert property (!sck_q && serial_clk && nf == 5'h0D |-> ##[0:6] !hold_active)
        else $error("hold not left at thirteenth rising edge");
    chk_shut_quiet: assert property (mode_shutdown && hi == 4'hF |=> mode_shutdown)
        else $error("shutdown left without a frame start");
    chk_power_off: assert property (mode_shutdown && hi == 4'hF |-> !analog_power_on)
        else $error("analog power on in shutdown");
    chk_to_shutdown: assert property ($rose(frame_select_n) && nf >= 5'h02 && nf < 5'h0A
        |-> ##[1:8] mode_shutdown)
        else $error("early abort did not enter shutdown");
    chk_keep_mode: assert property ($rose(frame_select_n) && nf < 5'h02
        |-> ##8 mode_shutdown == start_shut)
        else $error("mode changed by a very short frame");
    chk_stay_normal: assert property ($rose(frame_select_n) && nf >= 5'h0A |-> ##8 !mode_shutdown)
        else $error("late abort left normal mode");
    chk_wake_power: assert property ($fell(frame_select_n) && mode_shutdown
        |-> ##[1:6] !powered_up)
        else $error("wake frame reported fully powered");
    chk_full_power: assert property (nf == 5'h10 && $past(nf) == 5'h0F |-> ##[0:8] powered_up)
        else $error("not powered after sixteen cycles");
endmodule
`default_nettype wire

// file: verif/frame_host.sv
// Host model driving frame select and serial clock, sampling serial data
`timescale 1ns/1ps
`default_nettype none
module frame_host #(parameter HALF = 160, parameter GAP = 640) (
    output logic frame_select_n,
    output logic serial_clk,
    input wire logic serial_data,
    output logic [13:0] captured
);
    // Clock parks high and stands still between frames
    initial begin
        frame_select_n = 1'b1;
        serial_clk = 1'b1;
        captured = 14'h0000;
    end
    // One frame of n falling edges; bits are taken on the following rising edges
    task automatic run(input int n);
        frame_select_n = 1'b0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b0;
            #HALF;
            serial_clk = 1'b1;
            // Fifteen bits arrive; the register keeps the last fourteen
            if (i < 15) captured = {captured[12:0], serial_data};
            #HALF;
        end
        frame_select_n = 1'b1;
        #GAP;
    endtask
endmodule
`default_nettype wire

// file: verif/serial_adc_frame_power_control_tb_top.sv
// Self-checking bench: frame outcomes, shifted words and result buffering
`timescale 1ns/1ps
`default_nettype none
module serial_adc_frame_power_control_tb_top;
    logic mclk, nrst, result_ready;
    logic ovf_seen = 1'b0;
    logic [11:0] sample_code;
    wire frame_select_n, serial_clk, serial_out, serial_out_oe, serial_out_line, analog_power_on;
    wire hold_active, powered_up, mode_shutdown, result_valid, result_overflow;
    wire [11:0] result_data;
    wire [13:0] captured;
    int err_count, tests_run, i;
    // Rows: falls per frame and the mode expected afterwards
    int row_n [9] = '{16, 1, 5, 1, 12, 9, 10, 2, 16};
    logic row_shut [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    // A released line shows the inverse of its last bit, so stale data cannot pass
    assign serial_out_line = serial_out_oe ? serial_out : ~serial_out;
    always @(posedge mclk) if (result_overflow === 1'b1) ovf_seen <= 1'b1;
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    frame_host i_frame_host (.frame_select_n(frame_select_n), .serial_clk(serial_clk),
        .serial_data(serial_out_line), .captured(captured));
    adc_frame_ctrl #(.WIDTH(12), .DEPTH(16)) i_adc_frame_ctrl (.mclk(mclk), .nrst(nrst),
        .frame_select_n(frame_select_n), .serial_clk(serial_clk), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .sample_code(sample_code),
        .analog_power_on(analog_power_on), .hold_active(hold_active), .powered_up(powered_up),
        .mode_shutdown(mode_shutdown), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data),
        .result_overflow(result_overflow));
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_word(input string what, input logic [13:0] exp, input logic [13:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic frame(input int n, input logic [11:0] code);
        @(posedge mclk);
        #7;
        sample_code = code;
        i_frame_host.run(n);
    endtask
    // Takes one result; the valid flag rides in the compared word
    task automatic pop(input logic [11:0] exp);
        for (int k = 0; k < 40 && result_valid !== 1'b1; k++) begin
            @(posedge mclk);
            #7;
        end
        chk_word("result", {2'b01, exp}, {1'b0, result_valid, result_data});
        result_ready = 1'b1;
        @(posedge mclk);
        #7;
        result_ready = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        result_ready = 1'b0;
        sample_code = 12'h000;
        repeat (16) @(posedge mclk);
        #7;
        nrst = 1'b1;
        repeat (8) @(posedge mclk);
        for (i = 0; i < 9; i++) begin
            frame(row_n[i], i ? 12'hA5C : 12'hFFF);
            chk_bit("mode_shutdown", row_shut[i], mode_shutdown);
            if (row_n[i] == 16)
                chk_word("captured", {2'b00, i ? 12'hA5C : 12'hFFF}, captured);
            $display("row %0d done", i);
        end
        chk_bit("result_valid", 1'b0, result_valid);
        // Far side stalls while seventeen samples arrive; the last finds the buffer full
        for (i = 0; i < 17; i++) frame(16, 12'h100 + i[11:0]);
        chk_bit("overflow_seen", 1'b1, ovf_seen);
        for (i = 0; i < 16; i++) pop(12'h100 + i[11:0]);
        chk_bit("result_valid", 1'b0, result_valid);
        $display("buffer test done");
        // Mid-run reset while a sample waits and the device sits in shutdown
        frame(16, 12'h3C5);
        frame(5, 12'h000);
        chk_bit("mode_shutdown", 1'b1, mode_shutdown);
        chk_bit("result_valid", 1'b1, result_valid);
        @(posedge mclk);
        #7;
        nrst = 1'b0;
        @(posedge mclk);
        #7;
        chk_bit("mode_shutdown", 1'b0, mode_shutdown);
        chk_bit("analog_power_on", 1'b1, analog_power_on);
        chk_bit("powered_up", 1'b1, powered_up);
        chk_bit("serial_out_oe", 1'b0, serial_out_oe);
        chk_bit("result_valid", 1'b0, result_valid);
        repeat (15) @(posedge mclk);
        #7;
        nrst = 1'b1;
        repeat (8) @(posedge mclk);
        // First full frame after reset is a dummy and is never buffered
        frame(16, 12'h5A3);
        chk_bit("result_valid", 1'b0, result_valid);
        frame(16, 12'h6B4);
        chk_word("captured", 14'h06B4, captured);
        pop(12'h6B4);
        $display("reset test done");
        tally_and_finish;
    end
    // Watchdog set near thirteen times the expected run
    initial begin
        #2000000;
        err_count++;
        tally_and_finish;
    end
endmodule
bind adc_frame_ctrl adc_frame_ctrl_sva i_adc_frame_ctrl_sva (.mclk(mclk), .nrst(nrst),
    .frame_select_n(frame_select_n), .serial_clk(serial_clk), .serial_out_oe(serial_out_oe),
    .hold_active(hold_active), .powered_up(powered_up), .mode_shutdown(mode_shutdown),
    .analog_power_on(analog_power_on));
`default_nettype wire
